/* File: ebf_pkg.sv */
package ebf_pkg;
  // ****************************************
  // processor modes and bus format codes
  // ****************************************
  localparam logic [1:0] MODE_SINGLE   = 2'h0;
  localparam logic [1:0] MODE_EXPAND   = 2'h1;
  localparam logic [1:0] MODE_MICRO    = 2'h3;
  localparam logic [1:0] MUX_NONE      = 2'h0;
  localparam logic [1:0] MUX_AREA_ONE  = 2'h1;
  localparam logic [1:0] MUX_AREA_TWO  = 2'h2;
  localparam logic [1:0] MUX_WHOLE     = 2'h3;
  localparam int         MUX_FIELD_LO  = 4;
  localparam int         MUX_FIELD_HI  = 5;
  localparam logic [1:0] AREA_OTHER    = 2'h0;
  localparam logic [1:0] AREA_ONE      = 2'h1;
  localparam logic [1:0] AREA_TWO      = 2'h2;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W  = 20;
  localparam int PIN_W   = 16;
  localparam int BYTE_W  = 8;
  localparam int DATA_W  = 16;
  localparam int UPPER_W = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_HOLD, ST_DATA, ST_WAIT, ST_END
  } ebf_state_e;

  typedef struct packed {
    logic [1:0] procMode;
    logic [1:0] muxSpaceSel;
    logic       swWaitEn;
    logic       upperPortSel;
  } ebf_cfg_s;

  typedef struct packed {
    logic              write;
    logic [1:0]        area;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebf_req_s;
endpackage

/* File: ebf_bus_format.sv */
`timescale 1ns/1ps
// Summary of operation
// - two-bit field selects separate or multiplexed format
// - separate: width pin high frees high port
// - optional software wait on separate bus
// - 8-bit mux shares D0-7 with A0-7
// - 16-bit mux shares D0-7 with A1-8
// - 16-bit mux devices sit at even addresses
// - latch strobe driven on latch strobe pin
// - separate after reset; no whole-mux in micro
// - whole-space mux turns upper address into ports
// - codes 01/10 mux one area; 00 none
// - upper pins: select 1 port, 0 address
// - separate bus: shared pins output address only
// - external signals only in expansion/micro modes
// - twenty-line address bus over one megabyte
// - address undefined until first external access
module ebf_bus_format (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // configuration
  input  wire logic                           cnvssPin,
  input  wire logic                           busWidthPin,
  input  wire logic                           cfgLoad,
  input  wire ebf_pkg::ebf_cfg_s              cfgIn,
  output logic                                addrKnown,
  // access request
  input  wire logic                           reqValid,
  input  wire ebf_pkg::ebf_req_s              req,
  output logic                                reqReady,
  output logic                                rspValid,
  output logic [ebf_pkg::DATA_W-1:0]          rspData,
  // low_data_port and high_data_port pins
  input  wire logic [ebf_pkg::BYTE_W-1:0]     lowDataIn,
  output logic [ebf_pkg::BYTE_W-1:0]          lowDataOut,
  output logic                                lowDataOe,
  input  wire logic [ebf_pkg::BYTE_W-1:0]     highDataIn,
  output logic [ebf_pkg::BYTE_W-1:0]          highDataOut,
  output logic                                highDataOe,
  // address pins A0..A15, upper_addr_port_pins A16..A19
  input  wire logic [ebf_pkg::PIN_W-1:0]      addrPinIn,
  output logic [ebf_pkg::PIN_W-1:0]           addrPinOut,
  output logic [ebf_pkg::PIN_W-1:0]           addrPinOe,
  output logic [ebf_pkg::UPPER_W-1:0]         upperAddrOut,
  // control pins
  output logic                                latchStrobe,
  output logic                                rdStrobeN,
  output logic                                wrStrobeN,
  // pin roles, low means general i/o
  output logic                                lowPortIsBus,
  output logic                                highPortIsBus,
  output logic                                addrLoIsBus,
  output logic                                addrHiIsBus,
  output logic                                upperIsBus
);
  import ebf_pkg::*;

  // ****************************************
  // configuration state
  // ****************************************
  logic [1:0]        procMode_r, procMode_nxt;
  logic [1:0]        muxSel_r, muxSel_nxt;
  logic              waitEn_r, waitEn_nxt;
  logic              upperSel_r, upperSel_nxt;
  logic              strapDone_r, strapDone_nxt;
  logic              addrKnown_r, addrKnown_nxt;
  logic              extMode, wholeMux;
  ebf_state_e        state_r, state_nxt;

  assign extMode  = (procMode_r == MODE_EXPAND) || (procMode_r == MODE_MICRO);
  assign wholeMux = extMode && (muxSel_r == MUX_WHOLE);

  // strap caught on the first clock after release; whole-space mux refused in micro mode
  always_comb begin
    procMode_nxt  = procMode_r;
    muxSel_nxt    = muxSel_r;
    waitEn_nxt    = waitEn_r;
    upperSel_nxt  = upperSel_r;
    strapDone_nxt = 1'b1;
    addrKnown_nxt = addrKnown_r;
    if (!strapDone_r) begin
      procMode_nxt = cnvssPin ? MODE_MICRO : MODE_SINGLE;
    end else if (cfgLoad) begin
      procMode_nxt = cfgIn.procMode;
      waitEn_nxt   = cfgIn.swWaitEn;
      upperSel_nxt = cfgIn.upperPortSel;
      if (!(cfgIn.muxSpaceSel == MUX_WHOLE && cfgIn.procMode == MODE_MICRO)) begin
        muxSel_nxt = cfgIn.muxSpaceSel;
      end else if (muxSel_r == MUX_WHOLE) begin
        // a held whole-space code must not survive the move into micro mode
        muxSel_nxt = MUX_NONE;
      end
    end
    // address is stale until the first external cycle after leaving single-chip
    if (procMode_r == MODE_SINGLE && procMode_nxt != MODE_SINGLE) begin
      addrKnown_nxt = 1'b0;
    end else if (state_r == ST_ADDR && extMode) begin
      addrKnown_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      procMode_r  <= MODE_SINGLE;
      muxSel_r    <= MUX_NONE;
      waitEn_r    <= 1'b0;
      upperSel_r  <= 1'b0;
      strapDone_r <= 1'b0;
      addrKnown_r <= 1'b0;
    end else begin
      procMode_r  <= procMode_nxt;
      muxSel_r    <= muxSel_nxt;
      waitEn_r    <= waitEn_nxt;
      upperSel_r  <= upperSel_nxt;
      strapDone_r <= strapDone_nxt;
      addrKnown_r <= addrKnown_nxt;
    end
  end
  assign addrKnown = addrKnown_r;

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  ebf_req_s          cyc_r, cyc_nxt;
  logic              cycMux_r, cycMux_nxt;
  logic              cycWide_r, cycWide_nxt;
  logic              waitCyc_r, waitCyc_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              rsp_r, rsp_nxt;
  logic              reqMux;
  logic [BYTE_W-1:0] sharedIn;

  // area decode comes from outside; only the format choice is made here
  assign reqMux = extMode && ((muxSel_r == MUX_AREA_ONE && req.area == AREA_ONE) ||
                              (muxSel_r == MUX_AREA_TWO && req.area == AREA_TWO) ||
                              (muxSel_r == MUX_WHOLE && procMode_r == MODE_EXPAND));
  // shared lines move up one bit on a wide mux bus, so A0 never reaches them
  assign sharedIn = cycWide_r ? addrPinIn[BYTE_W:1] : addrPinIn[BYTE_W-1:0];
  assign reqReady = (state_r == ST_IDLE) && strapDone_r;

  always_comb begin
    state_nxt   = state_r;
    cyc_nxt     = cyc_r;
    cycMux_nxt  = cycMux_r;
    cycWide_nxt = cycWide_r;
    waitCyc_nxt = waitCyc_r;
    rdata_nxt   = rdata_r;
    rsp_nxt     = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (reqValid && reqReady) begin
          cyc_nxt     = req;
          cycMux_nxt  = reqMux;
          cycWide_nxt = !busWidthPin;
          waitCyc_nxt = waitEn_r;
          state_nxt   = ST_ADDR;
        end
      end
      ST_ADDR: state_nxt = cycMux_r ? ST_HOLD : ST_DATA;
      ST_HOLD: state_nxt = ST_DATA;
      ST_DATA: state_nxt = waitCyc_r ? ST_WAIT : ST_END;
      ST_WAIT: state_nxt = ST_END;
      ST_END: begin
        if (!cyc_r.write) begin
          rdata_nxt[BYTE_W-1:0]      = cycMux_r ? sharedIn : lowDataIn;
          rdata_nxt[DATA_W-1:BYTE_W] = cycWide_r ? highDataIn : {BYTE_W{1'b0}};
        end
        rsp_nxt   = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      cyc_r     <= '0;
      cycMux_r  <= 1'b0;
      cycWide_r <= 1'b0;
      waitCyc_r <= 1'b0;
      rdata_r   <= '0;
      rsp_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cyc_r     <= cyc_nxt;
      cycMux_r  <= cycMux_nxt;
      cycWide_r <= cycWide_nxt;
      waitCyc_r <= waitCyc_nxt;
      rdata_r   <= rdata_nxt;
      rsp_r     <= rsp_nxt;
    end
  end
  assign rspValid = rsp_r;
  assign rspData  = rdata_r;

  // ****************************************
  // pin roles and drive
  // ****************************************
  logic dataPhase, busy;
  assign busy      = (state_r != ST_IDLE);
  assign dataPhase = (state_r == ST_DATA) || (state_r == ST_WAIT) || (state_r == ST_END);

  // whole-space mux keeps only A0..A7 on the pins, 256 bytes per area
  assign lowPortIsBus  = extMode && !wholeMux;
  assign highPortIsBus = extMode && !busWidthPin && !wholeMux;
  assign addrLoIsBus   = extMode;
  assign addrHiIsBus   = extMode && !wholeMux;
  assign upperIsBus    = extMode && !wholeMux && !upperSel_r;

  // strobes stay idle in single-chip mode, the cycle is timed anyway
  assign latchStrobe = extMode && busy && cycMux_r && (state_r == ST_ADDR);
  assign rdStrobeN   = !(extMode && dataPhase && !cyc_r.write && state_r != ST_END);
  assign wrStrobeN   = !(extMode && dataPhase && cyc_r.write && state_r != ST_END);

  assign upperAddrOut = cyc_r.addr[ADDR_W-1:PIN_W];
  assign lowDataOut   = cyc_r.wdata[BYTE_W-1:0];
  assign highDataOut  = cyc_r.wdata[DATA_W-1:BYTE_W];
  assign lowDataOe    = extMode && dataPhase && cyc_r.write && !cycMux_r;
  assign highDataOe   = extMode && dataPhase && cyc_r.write && cycWide_r;

  // shared lines carry address first, then data; separate bus keeps address
  always_comb begin
    addrPinOut = cyc_r.addr[PIN_W-1:0];
    addrPinOe  = extMode ? {PIN_W{1'b1}} : {PIN_W{1'b0}};
    if (extMode && cycMux_r && dataPhase) begin
      if (cycWide_r) begin
        addrPinOut[BYTE_W:1] = cyc_r.wdata[BYTE_W-1:0];
        addrPinOe[BYTE_W:1]  = {BYTE_W{cyc_r.write}};
      end else begin
        addrPinOut[BYTE_W-1:0] = cyc_r.wdata[BYTE_W-1:0];
        addrPinOe[BYTE_W-1:0]  = {BYTE_W{cyc_r.write}};
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_ALE_ONLY_MUX: assert property (latchStrobe |-> cycMux_r && state_r == ST_ADDR)
    else $error("latch strobe outside a multiplexed address phase");
  AST_ALE_BEFORE_DATA: assert property ($rose(state_r == ST_DATA) && cycMux_r
    |-> $past(latchStrobe, 2))
    else $error("mux data phase not preceded by latch strobe");
  AST_SEP_ADDR_ONLY: assert property (extMode && busy && !cycMux_r
    |-> addrPinOut == cyc_r.addr[PIN_W-1:0] && addrPinOe == {PIN_W{1'b1}})
    else $error("separate bus shared pins not carrying address");
  AST_NARROW_FREE_HIGH: assert property (busWidthPin |-> !highPortIsBus && !highDataOe)
    else $error("high data port used on narrow bus");
  AST_WAIT_STATE: assert property (state_r == ST_DATA && waitCyc_r
    |=> state_r == ST_WAIT ##1 state_r == ST_END)
    else $error("software wait not inserted");
  AST_NO_WHOLE_MICRO: assert property (procMode_r == MODE_MICRO |-> muxSel_r != MUX_WHOLE)
    else $error("whole-space mux active in microprocessor mode");
  AST_WHOLE_PORTS: assert property (wholeMux |-> !upperIsBus && !addrHiIsBus)
    else $error("upper address still on bus in whole-space mux");
  AST_SINGLE_QUIET: assert property (procMode_r == MODE_SINGLE
    |-> rdStrobeN && wrStrobeN && !latchStrobe && addrPinOe == '0)
    else $error("external signals active in single-chip mode");
  AST_UPPER_SELECT: assert property (extMode && !wholeMux
    |-> upperIsBus == !upperSel_r)
    else $error("upper pin role does not follow select bit");
  AST_ADDR_STALE: assert property ($past(procMode_r) == MODE_SINGLE && procMode_r == MODE_EXPAND
    && $past(state_r) != ST_ADDR |-> !addrKnown)
    else $error("address marked known before first access");
  AST_WIDE_MUX_SHIFT: assert property (extMode && cycMux_r && cycWide_r && dataPhase
    && cyc_r.write |-> addrPinOut[BYTE_W:1] == cyc_r.wdata[BYTE_W-1:0])
    else $error("wide mux data not on A1..A8 lines");

  COV_MUX_WRITE: cover property (latchStrobe ##2 !wrStrobeN);
  COV_SEP_READ_WAIT: cover property (!cycMux_r && state_r == ST_WAIT && !rdStrobeN);
  COV_WHOLE_SPACE: cover property (wholeMux && rspValid);
endmodule

/* File: ebf_ext_mem.sv */
`timescale 1ns/1ps
// ****************************************
// external memory on the far side of the bus
// ****************************************
module ebf_ext_mem (
  // clock
  input  wire logic        clk,
  // pins driven by the device
  input  wire logic [15:0] addrPinOut,
  input  wire logic [15:0] addrPinOe,
  input  wire logic        latchStrobe,
  input  wire logic        rdStrobeN,
  input  wire logic        wide,
  // read data back to the device
  output logic [7:0]       lowDataIn,
  output logic [7:0]       highDataIn,
  output logic [15:0]      addrPinIn
);
  logic [7:0]  key_r  = 8'h00;
  logic        hold_r = 1'b0;
  logic        drv;
  logic [15:0] shared;
  // address caught by the latch pulse, or straight off the pins on a separate read
  always_ff @(posedge clk) begin
    if (latchStrobe || (!rdStrobeN && addrPinOe[1])) key_r <= addrPinOut[7:0];
    hold_r <= !rdStrobeN;
  end
  // data holds one cycle past the strobe, then released lines show the inverse
  assign drv = !rdStrobeN || hold_r;
  assign shared = wide ? {7'h00, key_r ^ 8'h5A, 1'b0} : {8'h00, key_r ^ 8'h5A};
  assign lowDataIn = drv ? (key_r ^ 8'h5A) : ~(key_r ^ 8'h5A);
  assign highDataIn = drv ? (key_r ^ 8'hC3) : ~(key_r ^ 8'hC3);
  assign addrPinIn = drv ? shared : ~shared;
endmodule

/* File: external_bus_format_select_tb_top.sv */
`timescale 1ns/1ps
module external_bus_format_select_tb_top;
  import ebf_pkg::*;
  logic        clk, reset, cnvssPin, busWidthPin, cfgLoad, addrKnown, reqValid, reqReady;
  logic        rspValid, lowDataOe, highDataOe, latchStrobe, rdStrobeN, wrStrobeN;
  logic        lowPortIsBus, highPortIsBus, addrLoIsBus, addrHiIsBus, upperIsBus, oeV;
  ebf_cfg_s    cfgIn;
  ebf_req_s    req;
  logic [15:0] rspData, addrPinIn, addrPinOut, addrPinOe, wdV;
  logic [7:0]  lowDataIn, lowDataOut, highDataIn, highDataOut;
  logic [3:0]  upperAddrOut;
  int          failures, numChecks, cyc;

  ebf_bus_format u_ebf_bus_format (.clk(clk), .reset(reset), .cnvssPin(cnvssPin),
    .busWidthPin(busWidthPin), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .addrKnown(addrKnown),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .lowDataIn(lowDataIn), .lowDataOut(lowDataOut),
    .lowDataOe(lowDataOe), .highDataIn(highDataIn), .highDataOut(highDataOut),
    .highDataOe(highDataOe), .addrPinIn(addrPinIn), .addrPinOut(addrPinOut),
    .addrPinOe(addrPinOe), .upperAddrOut(upperAddrOut), .latchStrobe(latchStrobe),
    .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .lowPortIsBus(lowPortIsBus),
    .highPortIsBus(highPortIsBus), .addrLoIsBus(addrLoIsBus), .addrHiIsBus(addrHiIsBus),
    .upperIsBus(upperIsBus));

  ebf_ext_mem u_ebf_ext_mem (.clk(clk), .addrPinOut(addrPinOut), .addrPinOe(addrPinOe),
    .latchStrobe(latchStrobe), .rdStrobeN(rdStrobeN), .wide(!busWidthPin),
    .lowDataIn(lowDataIn), .highDataIn(highDataIn), .addrPinIn(addrPinIn));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: the whole sequence needs under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected read word for a given low address byte
  function automatic logic [15:0] ed(input logic [7:0] key, input logic wide);
    return wide ? {key ^ 8'hC3, key ^ 8'h5A} : {8'h00, key ^ 8'h5A};
  endfunction

  task automatic setCfg(input logic [1:0] m, input logic [1:0] x, input logic w,
                        input logic u);
    @(negedge clk);
    cfgIn = '{m, x, w, u};
    cfgLoad = 1'b1;
    @(negedge clk);
    cfgLoad = 1'b0;
  endtask

  // one access: latency, latch pulses and, for reads, the returned word
  task automatic access(input logic wr, input logic [1:0] ar, input logic [19:0] ad,
                        input int lat, input int nl, input logic dchk,
                        input logic [15:0] exp);
    int k;
    int lt;
    k = 0;
    lt = 0;
    oeV = 1'b0;
    while (!reqReady && k < 20) begin
      @(negedge clk);
      k++;
    end
    req = '{wr, ar, ad, 16'hA5C3};
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    k = 0;
    while (!rspValid && k < 10) begin
      lt += int'(latchStrobe);
      oeV = oeV | lowDataOe | highDataOe | (|addrPinOe);
      if (!wrStrobeN) wdV = {highDataOut, lowDataOut};
      @(negedge clk);
      k++;
    end
    check(16'(k + 1), 16'(lat));
    check(16'(lt), 16'(nl));
    if (dchk && !wr) check(rspData, exp);
  endtask

  initial begin
    reset = 1'b1;
    cnvssPin = 1'b0;
    busWidthPin = 1'b0;
    cfgLoad = 1'b0;
    reqValid = 1'b0;
    cfgIn = '0;
    req = '0;
    failures = 0;
    numChecks = 0;
    cyc = 0;
    repeat (5) @(negedge clk);
    check(16'({reqReady, addrKnown, rdStrobeN, wrStrobeN, latchStrobe, lowDataOe}), 16'h000C);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check(16'({lowPortIsBus, highPortIsBus, addrLoIsBus, upperIsBus}), 16'h0000);
    access(1'b0, AREA_OTHER, 20'h00010, 4, 0, 1'b0, 16'h0000);
    check(16'(oeV), 16'h0000);
    setCfg(MODE_EXPAND, MUX_NONE, 1'b0, 1'b0);
    check(16'({lowPortIsBus, highPortIsBus, upperIsBus, addrKnown}), 16'h000E);
    access(1'b0, AREA_OTHER, 20'h12344, 4, 0, 1'b1, ed(8'h44, 1'b1));
    check(16'(upperAddrOut), 16'h0001);
    check(16'(addrKnown), 16'h0001);
    access(1'b1, AREA_ONE, 20'h00222, 4, 0, 1'b0, 16'h0000);
    check(wdV, 16'hA5C3);
    busWidthPin = 1'b1;
    setCfg(MODE_EXPAND, MUX_NONE, 1'b1, 1'b1);
    check(16'({highPortIsBus, upperIsBus}), 16'h0000);
    access(1'b0, AREA_OTHER, 20'h00456, 5, 0, 1'b1, ed(8'h56, 1'b0));
    busWidthPin = 1'b0;
    setCfg(MODE_EXPAND, MUX_AREA_ONE, 1'b1, 1'b0);
    access(1'b0, AREA_ONE, 20'h00188, 6, 1, 1'b1, ed(8'h88, 1'b1));
    access(1'b1, AREA_ONE, 20'h00188, 6, 1, 1'b0, 16'h0000);
    access(1'b0, AREA_TWO, 20'h00188, 5, 0, 1'b1, ed(8'h88, 1'b1));
    setCfg(MODE_EXPAND, MUX_AREA_TWO, 1'b1, 1'b0);
    access(1'b0, AREA_TWO, 20'h0019A, 6, 1, 1'b1, ed(8'h9A, 1'b1));
    busWidthPin = 1'b1;
    setCfg(MODE_EXPAND, MUX_WHOLE, 1'b1, 1'b0);
    check(16'(addrHiIsBus), 16'h0000);
    access(1'b0, AREA_OTHER, 20'h00077, 6, 1, 1'b1, ed(8'h77, 1'b0));
    setCfg(MODE_MICRO, MUX_WHOLE, 1'b1, 1'b0);
    check(16'(addrHiIsBus), 16'h0001);
    setCfg(MODE_MICRO, MUX_NONE, 1'b1, 1'b0);
    setCfg(MODE_MICRO, MUX_WHOLE, 1'b1, 1'b0);
    access(1'b0, AREA_OTHER, 20'h00033, 5, 0, 1'b1, ed(8'h33, 1'b0));
    setCfg(MODE_SINGLE, MUX_NONE, 1'b1, 1'b0);
    setCfg(MODE_EXPAND, MUX_NONE, 1'b1, 1'b0);
    check(16'(addrKnown), 16'h0000);
    // second reset with the strap high: micro mode, separate bus
    reset = 1'b1;
    cnvssPin = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check(16'(reqReady), 16'h0000);
    repeat (2) @(negedge clk);
    check(16'({lowPortIsBus, addrHiIsBus, upperIsBus}), 16'h0007);
    access(1'b0, AREA_OTHER, 20'h00066, 4, 0, 1'b1, ed(8'h66, 1'b0));
    tally_and_finish;
  end
endmodule
